// ### bench/host_model.sv
module host_model (
   input  wire logic                  core_clk_i,
   input  wire logic                  supply_ok_i,
   input  wire logic                  cmd_ack_i,
   output logic                       enable_o,
   output logic                       cmd_valid_o,
   output otp_loader_pkg::cmd_kind_type cmd_kind_o,
   output logic [3:0]                 cmd_addr_o,
   output logic [7:0]                 cmd_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import otp_loader_pkg::*;
   initial begin
      enable_o = 1'b0;
      cmd_valid_o = 1'b0;
      cmd_kind_o = CMD_READ;
      cmd_addr_o = 4'h0;
      cmd_data_o = 8'h00;
   end
   task automatic power_on();
      while (!supply_ok_i) @(posedge core_clk_i);
      @(posedge core_clk_i);
      enable_o <= 1'b1;
   endtask
   task automatic hold_low(input int n);
      @(posedge core_clk_i);
      enable_o <= 1'b0;
      repeat (n) @(posedge core_clk_i);
      enable_o <= 1'b1;
   endtask
   task automatic send(input cmd_kind_type k, input logic [3:0] a,
                       input logic [7:0] d, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      @(posedge core_clk_i);
      cmd_valid_o <= 1'b1;
      cmd_kind_o <= k;
      cmd_addr_o <= a;
      cmd_data_o <= d;
      while (!ok && n < 30) begin
         @(negedge core_clk_i);
         ok = cmd_ack_i;
         n++;
      end
      @(posedge core_clk_i);
      cmd_valid_o <= 1'b0;
      // Released lines go to the inverse so stale data never looks valid
      cmd_addr_o <= ~a;
      cmd_data_o <= ~d;
   endtask
endmodule // host_model

// ### bench/loader_chk.sv
`include "otp_loader_defines.svh"
module loader_chk #(
   parameter logic [`LOW_CNT_W-1:0] ENABLE_LOW_CYCLES = 16'h0014
) (
   input wire logic                         core_clk_i,
   input wire logic                         rst_b_i,
   input wire logic                         enable_i,
   input wire logic                         cmd_valid_i,
   input wire otp_loader_pkg::cmd_kind_type cmd_kind_i,
   input wire logic                         cmd_ack_o,
   input wire logic                         rd_valid_o,
   input wire logic                         prog_valid_i,
   input wire logic                         prog_done_o,
   input wire logic                         prog_reject_o,
   input wire logic [`CHANNELS-1:0]         chan_enable_o,
   input wire logic                         config_loaded_o,
   input wire logic                         shutdown_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import otp_loader_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic [15:0] low_cnt;
   // Saturates so a long shutdown never wraps to zero
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) low_cnt <= 16'h0000;
      else if (enable_i) low_cnt <= 16'h0000;
      else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
   end
   ack_gate_a:
      assert property (cmd_ack_o == (cmd_valid_i && config_loaded_o))
         else $error("ack not tied to loaded flag");
   load_wait_a:
      assert property (shutdown_o && enable_i |=> !config_loaded_o [*8])
         else $error("loaded flag too early");
   load_done_a:
      assert property (shutdown_o && enable_i |-> ##[9:10] config_loaded_o)
         else $error("load did not finish");
   shut_idle_a:
      assert property (shutdown_o && $past(shutdown_o) |->
         !config_loaded_o && chan_enable_o == 4'h0)
         else $error("activity in shutdown");
   low_shut_a:
      assert property (low_cnt > ENABLE_LOW_CYCLES + 16'h0002 |-> shutdown_o)
         else $error("long enable low kept running");
   rd_pulse_a:
      assert property (cmd_ack_o && cmd_kind_i == CMD_READ |=> rd_valid_o)
         else $error("read data missing");
   rd_only_a:
      assert property (!(cmd_ack_o && cmd_kind_i == CMD_READ) |=> !rd_valid_o)
         else $error("stray read pulse");
   prog_resp_a:
      assert property (prog_valid_i |=> prog_done_o != prog_reject_o)
         else $error("program answer wrong");
   prog_quiet_a:
      assert property (!prog_valid_i |=> !prog_done_o && !prog_reject_o)
         else $error("stray program answer");
   restart_a:
      assert property (cmd_ack_o && cmd_kind_i == CMD_RESTART |->
         ##[1:3] !config_loaded_o)
         else $error("restart ignored");
   chan_ready_a:
      assert property (chan_enable_o != 4'h0 |->
         config_loaded_o || $past(config_loaded_o))
         else $error("channel on while not loaded");
endmodule // loader_chk

bind otp_config_power_up_loader loader_chk #(
   .ENABLE_LOW_CYCLES(ENABLE_LOW_CYCLES)
) u_chk (.core_clk_i, .rst_b_i, .enable_i, .cmd_valid_i, .cmd_kind_i,
   .cmd_ack_o, .rd_valid_o, .prog_valid_i, .prog_done_o, .prog_reject_o,
   .chan_enable_o, .config_loaded_o, .shutdown_o);

// ### bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import otp_loader_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, sup = 1'b0, en, cv, ack, rv, ok;
   logic pv = 1'b0, pd, pr, ld, sd;
   cmd_kind_type ck;
   logic [3:0] ca, pin = 4'h0, chn;
   logic [7:0] cd, rdat, pdat = 8'h00;
   logic [2:0] pa = 3'h0;
   int err_count = 0, num_checks = 0;
   always #4 clk = ~clk;
   otp_config_power_up_loader #(.ENABLE_LOW_CYCLES(16'h0014)) uut (
      .core_clk_i(clk), .rst_b_i(rst_b), .enable_i(en), .cmd_valid_i(cv),
      .cmd_kind_i(ck), .cmd_addr_i(ca), .cmd_data_i(cd), .cmd_ack_o(ack),
      .rd_valid_o(rv), .rd_data_o(rdat), .prog_valid_i(pv),
      .prog_addr_i(pa), .prog_data_i(pdat), .prog_done_o(pd),
      .prog_reject_o(pr), .fb_value_i(32'h44332211), .chan_pin_i(pin),
      .chan_enable_o(chn), .config_loaded_o(ld), .shutdown_o(sd));
   host_model u_host (.core_clk_i(clk), .supply_ok_i(sup), .cmd_ack_i(ack),
      .enable_o(en), .cmd_valid_o(cv), .cmd_kind_o(ck), .cmd_addr_o(ca),
      .cmd_data_o(cd));
   task automatic chk(input string n, input logic [7:0] g, e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results();
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic prog(input logic [2:0] a, input logic [7:0] d, input e);
      logic dn = 1'b0, rj = 1'b0;
      @(posedge clk);
      pv <= 1'b1;
      pa <= a;
      pdat <= d;
      @(posedge clk);
      pv <= 1'b0;
      repeat (2) begin
         @(negedge clk);
         dn |= pd;
         rj |= pr;
      end
      chk("prog done", dn, e);
      chk("prog reject", rj, !e);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      u_host.send(CMD_READ, a, 8'h00, ok);
      chk("read ack", ok, 1'b1);
      @(negedge clk);
      chk("read valid", rv, 1'b1);
      chk("read", rdat, e);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      u_host.send(CMD_WRITE, a, d, ok);
      chk("write ack", ok, 1'b1);
   endtask
   task automatic wait_ld();
      for (int i = 0; i < 40 && !ld; i++) @(negedge clk);
      chk("loaded", ld, 1'b1);
   endtask
   task automatic t_program();
      prog(3'h0, 8'h39, 1'b1);
      prog(3'h1, 8'h04, 1'b1);
      prog(3'h2, 8'hA5, 1'b1);
      prog(3'h2, 8'h5A, 1'b0);
      prog(3'h2, 8'hF5, 1'b1);
      u_host.send(CMD_READ, 4'h0, 8'h00, ok);
      chk("early ack", ok, 1'b0);
   endtask
   task automatic t_power();
      sup <= 1'b1;
      u_host.power_on();
      wait_ld();
      rd(4'h0, 8'h39);
      rd(4'h2, 8'hF5);
      @(posedge clk);
      pin <= 4'h2;
      repeat (3) @(negedge clk);
      chk("chan pin on", chn, 4'h7);
      @(posedge clk);
      pin <= 4'h0;
      repeat (3) @(negedge clk);
      chk("chan pin off", chn, 4'h5);
   endtask
   task automatic t_write();
      wr(4'h2, 8'h11);
      rd(4'h2, 8'h11);
      wr(4'h1, 8'h00);
      repeat (3) @(negedge clk);
      chk("chan bus off", chn, 4'h1);
      wr(4'h8, 8'hFF);
      wr(4'hF, 8'hFF);
      rd(4'h8, 8'h11);
      rd(4'h9, 8'h22);
      // Stray decode of those writes would land in a control register
      rd(4'h0, 8'h39);
      rd(4'h7, 8'h00);
      rd(4'hF, 8'h00);
   endtask
   task automatic t_restart();
      u_host.send(CMD_RESTART, 4'h0, 8'h00, ok);
      for (int i = 0; i < 5 && ld; i++) @(negedge clk);
      chk("restart drop", ld, 1'b0);
      wait_ld();
      rd(4'h1, 8'h04);
   endtask
   task automatic t_enable();
      u_host.hold_low(10);
      #1;
      chk("short dip", sd, 1'b0);
      wr(4'h2, 8'h11);
      u_host.hold_low(30);
      #1;
      chk("long low", sd, 1'b1);
      wait_ld();
      rd(4'h2, 8'hF5);
   endtask
   // Generous bound: the whole sequence needs well under a thousand cycles
   initial begin
      #40us;
      err_count++;
      results();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_program();
      t_power();
      t_write();
      t_restart();
      t_enable();
      results();
   end
endmodule // testbench

// ### core/otp_cells.sv
`include "otp_loader_defines.svh"

module otp_cells (
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_b_i,
   input  wire logic                   prog_valid_i,
   input  wire logic [`OTP_ADDR_W-1:0] prog_addr_i,
   input  wire logic [`DATA_W-1:0]     prog_data_i,
   output logic                        prog_done_o,
   output logic                        prog_reject_o,
   input  wire logic [`OTP_ADDR_W-1:0] rd_addr_i,
   output logic [`DATA_W-1:0]          rd_data_o
);
   import otp_loader_pkg::*;

   logic [`DATA_W-1:0] cells      [`CTRL_WORDS];
   logic [`DATA_W-1:0] next_cells [`CTRL_WORDS];
   logic               next_done;
   logic               next_reject;
   logic [`DATA_W-1:0] cur;

   assign rd_data_o = cells[rd_addr_i];

   // A programmed bit reads 1 for good; asking it back to 0 is refused
   always_comb begin
      next_cells  = cells;
      next_done   = 1'b0;
      next_reject = 1'b0;
      cur         = cells[prog_addr_i];
      if (prog_valid_i) begin
         if ((cur & ~prog_data_i) != `CTRL_RESET) begin
            next_reject = 1'b1;
         end else begin
            next_cells[prog_addr_i] = cur | prog_data_i;
            next_done               = 1'b1;
         end
      end
   end

   // Reset stands for a blank part so simulation starts defined
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < `CTRL_WORDS; i++) begin
            cells[i] <= `CTRL_RESET;
         end
         prog_done_o   <= 1'b0;
         prog_reject_o <= 1'b0;
      end else begin
         cells         <= next_cells;
         prog_done_o   <= next_done;
         prog_reject_o <= next_reject;
      end
   end

endmodule // otp_cells

// ### core/otp_config_power_up_loader.sv
// Functional notes
// - Programmed configuration bits can never change again
// - Power-up copies whole configuration memory automatically
// - Control registers load from memory or bus
// - Feedback registers read-only; writes change nothing
// - Loaded flag set before bus commands acknowledged
// - Start always-on and asserted pin-controlled channels
// - Enable low past interval shuts down, reloads
// - Serial restart command acts like enable cycling
`include "otp_loader_defines.svh"

module otp_config_power_up_loader #(
   parameter logic [`LOW_CNT_W-1:0] ENABLE_LOW_CYCLES =
      `LOW_CNT_W'(`ENABLE_LOW_CYCLES)
) (
   input  wire logic                          core_clk_i,
   input  wire logic                          rst_b_i,
   input  wire logic                          enable_i,
   input  wire logic                          cmd_valid_i,
   input  wire otp_loader_pkg::cmd_kind_type  cmd_kind_i,
   input  wire logic [`ADDR_W-1:0]            cmd_addr_i,
   input  wire logic [`DATA_W-1:0]            cmd_data_i,
   output logic                               cmd_ack_o,
   output logic                               rd_valid_o,
   output logic [`DATA_W-1:0]                 rd_data_o,
   input  wire logic                          prog_valid_i,
   input  wire logic [`OTP_ADDR_W-1:0]        prog_addr_i,
   input  wire logic [`DATA_W-1:0]            prog_data_i,
   output logic                               prog_done_o,
   output logic                               prog_reject_o,
   input  wire logic [`FB_WORDS*`DATA_W-1:0]  fb_value_i,
   input  wire logic [`CHANNELS-1:0]          chan_pin_i,
   output logic [`CHANNELS-1:0]               chan_enable_o,
   output logic                               config_loaded_o,
   output logic                               shutdown_o
);
   import otp_loader_pkg::*;

   load_state_type            state;
   load_state_type            next_state;
   logic [`OTP_ADDR_W-1:0]    load_idx;
   logic [`OTP_ADDR_W-1:0]    next_load_idx;
   logic [`LOW_CNT_W-1:0]     low_cnt;
   logic [`LOW_CNT_W-1:0]     next_low_cnt;
   logic [`DATA_W-1:0]        ctrl      [`CTRL_WORDS];
   logic [`DATA_W-1:0]        next_ctrl [`CTRL_WORDS];
   logic [`DATA_W-1:0]        fb        [`FB_WORDS];
   logic [`DATA_W-1:0]        next_fb   [`FB_WORDS];
   logic                      next_loaded;
   logic                      next_rd_valid;
   logic [`DATA_W-1:0]        next_rd_data;
   logic [`DATA_W-1:0]        otp_data;
   logic [`CHANNELS-1:0]      next_chan_en;
   logic                      cmd_take;

   function automatic logic is_ctrl(input logic [`ADDR_W-1:0] a);
      return a < `ADDR_W'(`CTRL_WORDS);
   endfunction

   function automatic logic is_fb(input logic [`ADDR_W-1:0] a);
      return (a >= `FB_BASE) && (a < `FB_BASE + `ADDR_W'(`FB_WORDS));
   endfunction

   otp_cells u_otp_cells (
      .core_clk_i    (core_clk_i),
      .rst_b_i       (rst_b_i),
      .prog_valid_i  (prog_valid_i),
      .prog_addr_i   (prog_addr_i),
      .prog_data_i   (prog_data_i),
      .prog_done_o   (prog_done_o),
      .prog_reject_o (prog_reject_o),
      .rd_addr_i     (load_idx),
      .rd_data_o     (otp_data)
   );

   // Commands are answered only once configuration is in place
   assign cmd_take  = cmd_valid_i && config_loaded_o;
   assign cmd_ack_o = cmd_take;

   // Sequencer: shutdown, load from memory, ready
   always_comb begin
      next_state    = state;
      next_load_idx = load_idx;
      next_low_cnt  = `LOW_CNT_W'(0);
      if (!enable_i && state != ST_SHUTDOWN) begin
         // Short dips are ridden through, only a long low shuts down
         next_low_cnt = (low_cnt == ENABLE_LOW_CYCLES) ?
                        low_cnt : low_cnt + `LOW_CNT_W'(1);
      end
      unique case (state)
         ST_SHUTDOWN: begin
            // The host keeps enable low until the core supply is good
            if (enable_i) begin
               next_state    = ST_LOAD;
               next_load_idx = `OTP_ADDR_W'(0);
            end
         end
         ST_LOAD: begin
            if (low_cnt == ENABLE_LOW_CYCLES) begin
               next_state = ST_SHUTDOWN;
            end else if (load_idx == `OTP_ADDR_W'(`CTRL_WORDS - 1)) begin
               next_state = ST_READY;
            end else begin
               next_load_idx = load_idx + `OTP_ADDR_W'(1);
            end
         end
         ST_READY: begin
            if (low_cnt == ENABLE_LOW_CYCLES) begin
               next_state = ST_SHUTDOWN;
            end else if (cmd_take && cmd_kind_i == CMD_RESTART) begin
               next_state    = ST_LOAD;
               next_load_idx = `OTP_ADDR_W'(0);
            end
         end
         default: begin
            next_state = ST_SHUTDOWN;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state    <= ST_SHUTDOWN;
         load_idx <= `OTP_ADDR_W'(0);
         low_cnt  <= `LOW_CNT_W'(0);
      end else begin
         state    <= next_state;
         load_idx <= next_load_idx;
         low_cnt  <= next_low_cnt;
      end
   end

   // Control registers: memory image first, host writes on top
   always_comb begin
      next_ctrl = ctrl;
      if (state == ST_LOAD) begin
         next_ctrl[load_idx] = otp_data;
      end else if (cmd_take && cmd_kind_i == CMD_WRITE &&
                   is_ctrl(cmd_addr_i)) begin
         next_ctrl[cmd_addr_i[`OTP_ADDR_W-1:0]] = cmd_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < `CTRL_WORDS; i++) begin
            ctrl[i] <= `CTRL_RESET;
         end
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // Feedback registers follow the measurements, never the bus
   always_comb begin
      for (int i = 0; i < `FB_WORDS; i++) begin
         next_fb[i] = (state == ST_READY) ?
                      fb_value_i[i*`DATA_W +: `DATA_W] : `FB_RESET;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < `FB_WORDS; i++) begin
            fb[i] <= `FB_RESET;
         end
      end else begin
         fb <= next_fb;
      end
   end

   // Read answers; unmapped addresses read zero
   always_comb begin
      next_rd_valid = cmd_take && cmd_kind_i == CMD_READ;
      next_rd_data  = rd_data_o;
      if (next_rd_valid) begin
         if (is_ctrl(cmd_addr_i)) begin
            next_rd_data = ctrl[cmd_addr_i[`OTP_ADDR_W-1:0]];
         end else if (is_fb(cmd_addr_i)) begin
            next_rd_data = fb[2'(cmd_addr_i - `FB_BASE)];
         end else begin
            next_rd_data = `FB_RESET;
         end
      end
   end

   // Channel starts; registered so a mode write settles first
   generate
      for (genvar c = 0; c < `CHANNELS; c++) begin : g_chan
         logic [`MODE_W-1:0] mode;
         assign mode = ctrl[`CHAN_MODE_REG][c*`MODE_W +: `MODE_W];
         always_comb begin
            next_chan_en[c] = (state == ST_READY) &&
               ((mode == MODE_ALWAYS) ||
                (mode == MODE_PIN && chan_pin_i[c]) ||
                (mode == MODE_BUS && ctrl[`CHAN_BUS_EN_REG][c]));
         end
      end
   endgenerate

   assign next_loaded = (next_state == ST_READY);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_valid_o      <= 1'b0;
         rd_data_o       <= `FB_RESET;
         chan_enable_o   <= '0;
         config_loaded_o <= 1'b0;
         shutdown_o      <= 1'b1;
      end else begin
         rd_valid_o      <= next_rd_valid;
         rd_data_o       <= next_rd_data;
         chan_enable_o   <= next_chan_en;
         config_loaded_o <= next_loaded;
         shutdown_o      <= (next_state == ST_SHUTDOWN);
      end
   end

endmodule // otp_config_power_up_loader

// ### core/otp_loader_defines.svh
`ifndef OTP_LOADER_DEFINES_SVH
`define OTP_LOADER_DEFINES_SVH

`define DATA_W            8
`define ADDR_W            4
`define OTP_ADDR_W        3
`define CTRL_WORDS        8
`define FB_WORDS          4
`define FB_BASE           4'h8
`define CHANNELS          4
`define CTRL_RESET        8'h00
`define FB_RESET          8'h00
`define CHAN_MODE_REG     3'h0
`define CHAN_BUS_EN_REG   3'h1
`define MODE_W            2
`define CLK_PERIOD_NS     8
`define ENABLE_LOW_TIME_NS 100000
`define ENABLE_LOW_CYCLES \
   ((`ENABLE_LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_CNT_W         16

`endif

// ### core/otp_loader_pkg.sv
`include "otp_loader_defines.svh"

package otp_loader_pkg;

   typedef enum logic [2:0] {
      ST_SHUTDOWN = 3'b001,
      ST_LOAD     = 3'b010,
      ST_READY    = 3'b100
   } load_state_type;

   typedef enum logic [1:0] {
      CMD_WRITE   = 2'h0,
      CMD_READ    = 2'h1,
      CMD_RESTART = 2'h2
   } cmd_kind_type;

   typedef enum logic [1:0] {
      MODE_OFF    = 2'h0,
      MODE_ALWAYS = 2'h1,
      MODE_PIN    = 2'h2,
      MODE_BUS    = 2'h3
   } chan_mode_type;

endpackage
